/* dmcp_pkg.sv */
// Package for the host-side controller of the dual mode control port.
// Assumes a 200 MHz system clock and a device that answers on I2C or SPI.
package dmcp_pkg;
    localparam int CLK_MHZ = 200;
    localparam int I2C_KHZ = 400;
    localparam int I2C_QTR = CLK_MHZ * 1000 / (I2C_KHZ * 4);
    localparam int SPI_HALF = 10;
    localparam logic [4:0] I2C_ADDR_HI = 5'h13;
    localparam logic [6:0] I2C_BCAST_ADDR = 7'h4C;
    localparam logic [7:0] PAGE_REG = 8'h00;

    typedef struct packed {
        logic use_spi;
        logic read;
        logic bcast;
        logic [1:0] strap;
        logic [6:0] reg_addr;
        logic [7:0] wdata;
    } dmcp_req_s;

    typedef struct packed {
        logic ack_err;
        logic [7:0] rdata;
    } dmcp_rsp_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_START = 4'b0001,
        ST_BIT = 4'b0010,
        ST_ACK = 4'b0011,
        ST_RSTART = 4'b0100,
        ST_STOP = 4'b0101,
        ST_DONE = 4'b0110,
        ST_SPI = 4'b0111,
        ST_SPI_END = 4'b1000
    } dmcp_state_e;
endpackage : dmcp_pkg

/* dmcp_host.sv */
// Host controller driving the device control port over I2C or SPI pins.
// Assumes pull-ups on the I2C lines and the device on the same board.
// Contract
// - Host uses one protocol only, selected per request and fixed by user.
// - Bytes are eight bits MSB first, each acknowledged.
// - Start and stop change data while clock high; data changes while low.
// - Write is start, address with 0, register, data, stop.
// - Read writes register, repeated start, address with 1.
// - Master ends read with not-acknowledge then stop.
// - SPI master makes clock and drops select to begin.
// - SPI mode CPOL 0, CPHA 1.
// - SPI write stores the byte after the command.
// - Select stays low through all bytes.
// - Register 0 is the page selector.
// - Host avoids reserved pages and registers; dmcp_host sends any reg_addr it is given, unchecked.
`timescale 1ns/1ps
`default_nettype none
module dmcp_host
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_req_valid,
    input wire dmcp_pkg::dmcp_req_s i_req,
    output logic o_busy,
    output logic o_rsp_valid,
    output dmcp_pkg::dmcp_rsp_s o_rsp,
    output logic o_data_or_select_pin_o,
    output logic o_data_or_select_pin_oe_n,
    input wire logic i_data_or_select_pin,
    output logic o_scl_mosi_o,
    output logic o_scl_mosi_oe_n,
    output logic o_addr_strap0_or_serial_clock_pin,
    input wire logic i_addr_strap1_or_serial_out_pin
);
    import dmcp_pkg::*;

    dmcp_state_e st_q;
    dmcp_req_s req_q;
    logic [1:0] sda_sync_q, miso_sync_q;
    logic [15:0] tick_q;
    logic [1:0] ph_q;
    logic [4:0] bit_q;
    logic [1:0] byte_q;
    logic [7:0] sh_q, rx_q;
    logic err_q;
    logic sda_q, scl_q, sclk_q, ssn_q, mosi_q;
    logic tick;
    assign tick = (tick_q == 16'h0000);
    // Pins from the device pass two flip-flops before any use.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sda_sync_q <= 2'h3;
            miso_sync_q <= 2'h0;
        end
        else
        begin
            sda_sync_q <= {sda_sync_q[0], i_data_or_select_pin};
            miso_sync_q <= {miso_sync_q[0], i_addr_strap1_or_serial_out_pin};
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            tick_q <= 16'h0000;
        else if (st_q == ST_IDLE || tick)
            tick_q <= req_q.use_spi ? 16'(SPI_HALF - 1) : 16'(I2C_QTR - 1);
        else
            tick_q <= tick_q - 16'h0001;
    end
    // The I2C address byte: fixed high bits plus straps, or broadcast.
    function automatic logic [7:0] addr_byte(input dmcp_req_s r, input logic rd);
        logic [6:0] a;
        a = r.bcast ? I2C_BCAST_ADDR : {I2C_ADDR_HI, r.strap};
        return {a, rd};
    endfunction
    // I2C byte phases: 0 addr W, 1 reg, 2 write or read data, 3 addr R after restart.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_q <= ST_IDLE;
            req_q <= '0;
            ph_q <= 2'h0;
            bit_q <= 5'h00;
            byte_q <= 2'h0;
            sh_q <= 8'h00;
            rx_q <= 8'h00;
            err_q <= 1'b0;
            sda_q <= 1'b1;
            scl_q <= 1'b1;
            sclk_q <= 1'b0;
            ssn_q <= 1'b1;
            mosi_q <= 1'b0;
            o_rsp_valid <= 1'b0;
            o_rsp <= '0;
            o_busy <= 1'b0;
            o_data_or_select_pin_o <= 1'b0;
            o_data_or_select_pin_oe_n <= 1'b1;
            o_scl_mosi_o <= 1'b0;
            o_scl_mosi_oe_n <= 1'b1;
        end
        else
        begin
            o_rsp_valid <= 1'b0;
            // Pins are registered so that no mux glitch reaches the open-drain lines.
            o_data_or_select_pin_o <= req_q.use_spi ? ssn_q : 1'b0;
            o_data_or_select_pin_oe_n <= req_q.use_spi ? 1'b0 : sda_q;
            o_scl_mosi_o <= req_q.use_spi ? mosi_q : 1'b0;
            o_scl_mosi_oe_n <= req_q.use_spi ? 1'b0 : scl_q;
            case (st_q)
                ST_IDLE:
                begin
                    o_busy <= 1'b0;
                    if (i_req_valid)
                    begin
                        req_q <= i_req;
                        o_busy <= 1'b1;
                        err_q <= 1'b0;
                        ph_q <= 2'h0;
                        bit_q <= 5'h00;
                        if (i_req.use_spi)
                        begin
                            sh_q <= {i_req.reg_addr, i_req.read};
                            ssn_q <= 1'b0;
                            st_q <= ST_SPI;
                        end
                        else
                        begin
                            sh_q <= addr_byte(i_req, 1'b0);
                            st_q <= ST_START;
                        end
                    end
                end
                ST_START, ST_RSTART:
                    if (tick)
                    begin
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            2'h0: sda_q <= 1'b1;
                            2'h1: scl_q <= 1'b1;
                            2'h2: sda_q <= 1'b0;
                            default:
                            begin
                                scl_q <= 1'b0;
                                byte_q <= (st_q == ST_RSTART) ? 2'h3 : 2'h0;
                                st_q <= ST_BIT;
                            end
                        endcase
                    end
                ST_BIT:
                    if (tick)
                    begin
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            2'h0: sda_q <= (byte_q == 2'h2 && req_q.read)
                                ? 1'b1 : sh_q[7];
                            2'h1: scl_q <= 1'b1;
                            2'h2: rx_q <= {rx_q[6:0], sda_sync_q[1]};
                            default:
                            begin
                                scl_q <= 1'b0;
                                sh_q <= {sh_q[6:0], 1'b0};
                                bit_q <= bit_q + 5'h01;
                                if (bit_q == 5'h07)
                                    st_q <= ST_ACK;
                            end
                        endcase
                    end
                ST_ACK:
                    if (tick)
                    begin
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            // Always released: the slave acks, and read data gets a NACK.
                            2'h0: sda_q <= 1'b1;
                            2'h1: scl_q <= 1'b1;
                            2'h2:
                                if (!(byte_q == 2'h2 && req_q.read) && sda_sync_q[1])
                                    err_q <= 1'b1;
                            default:
                            begin
                                scl_q <= 1'b0;
                                bit_q <= 5'h00;
                                if (err_q || byte_q == 2'h2)
                                    st_q <= ST_STOP;
                                else if (byte_q == 2'h0)
                                begin
                                    byte_q <= 2'h1;
                                    sh_q <= {1'b0, req_q.reg_addr};
                                    st_q <= ST_BIT;
                                end
                                else if (byte_q == 2'h1 && req_q.read)
                                begin
                                    sh_q <= addr_byte(req_q, 1'b1);
                                    st_q <= ST_RSTART;
                                end
                                else if (byte_q == 2'h1)
                                begin
                                    byte_q <= 2'h2;
                                    sh_q <= req_q.wdata;
                                    st_q <= ST_BIT;
                                end
                                else
                                begin
                                    byte_q <= 2'h2;
                                    sh_q <= 8'hFF;
                                    st_q <= ST_BIT;
                                end
                            end
                        endcase
                    end
                ST_STOP:
                    if (tick)
                    begin
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            2'h0: sda_q <= 1'b0;
                            2'h1: scl_q <= 1'b1;
                            2'h2: sda_q <= 1'b1;
                            default: st_q <= ST_DONE;
                        endcase
                    end
                ST_SPI:
                    if (tick)
                    begin
                        // Drive on the rising edge, sample on the falling one.
                        sclk_q <= ~sclk_q;
                        if (!sclk_q)
                        begin
                            mosi_q <= sh_q[7];
                            sh_q <= {sh_q[6:0], 1'b0};
                        end
                        else
                        begin
                            rx_q <= {rx_q[6:0], miso_sync_q[1]};
                            bit_q <= bit_q + 5'h01;
                            if (bit_q == 5'h07)
                                sh_q <= req_q.wdata;
                            if (bit_q == 5'h0F)
                                st_q <= ST_SPI_END;
                        end
                    end
                ST_SPI_END:
                    if (tick)
                    begin
                        ssn_q <= 1'b1;
                        st_q <= ST_DONE;
                    end
                ST_DONE:
                begin
                    o_rsp_valid <= 1'b1;
                    o_rsp <= '{ack_err: err_q, rdata: rx_q};
                    st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    assign o_addr_strap0_or_serial_clock_pin = sclk_q;

    a_scl_low_change: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_q == ST_BIT && $changed(sda_q)) |-> !scl_q) else $error("data moved with clock high");
    a_spi_idle_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_q == ST_IDLE) |-> !sclk_q) else $error("spi clock not idle low");
    a_ss_held_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_q == ST_SPI) |-> !ssn_q) else $error("select rose mid frame");
    a_spi_sixteen: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_q == ST_SPI_END) |-> bit_q == 5'h10) else $error("frame not sixteen clocks");
    a_rsp_pulse: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_rsp_valid |=> !o_rsp_valid) else $error("response not one cycle");
    a_stop_rise: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_q == ST_STOP && ph_q == 2'h2 && tick) |=> (sda_q && scl_q)) else $error("bad stop");
    a_addr_fixed: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_q == ST_START && ph_q == 2'h0) |-> sh_q[7:3] == I2C_ADDR_HI) else $error("bad addr");
    a_nack_last: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_q == ST_ACK && byte_q == 2'h2 && req_q.read && ph_q == 2'h2) |-> sda_q)
        else $error("no nack on read");
    c_i2c_write: cover property (@(posedge i_clk) st_q == ST_STOP && !req_q.read);
    c_i2c_read: cover property (@(posedge i_clk) st_q == ST_RSTART);
    c_spi_frame: cover property (@(posedge i_clk) st_q == ST_SPI_END);
    c_page_sel: cover property (@(posedge i_clk)
        st_q == ST_DONE && !req_q.read && req_q.reg_addr == PAGE_REG[6:0]);
endmodule : dmcp_host
`default_nettype wire

/* dmcp_dev_model.sv */
// Behavioural model of the controlled device: a register file behind a two-wire
// slave and a four-wire serial slave. Assumes the bench resolves the wire levels.
`timescale 1ns/1ps
`default_nettype none
module dmcp_dev_model
(
    input wire logic i_spi,
    input wire logic [1:0] i_strap,
    input wire logic i_sda,
    input wire logic i_scl,
    input wire logic i_sclk,
    output logic o_sda_low,
    output logic o_miso
);
    logic [7:0] regs [128];
    logic [7:0] sh = 8'h00;
    logic [6:0] ptr = 7'h00;
    logic ack = 1'h0;
    logic rd = 1'h0;
    logic mq = 1'h0;
    int ph = 0;
    int bn = 0;
    int n = 0;

    // Protocol choice is a board input here, not inferred from pin activity.
    initial
    begin
        o_sda_low = 1'h0;
        foreach (regs[k]) regs[k] = 8'h00;
    end

    always @(negedge i_sda)
        if (i_spi)
            n = 0;
        else if (i_scl)
        begin
            ph = 1;
            bn = 0;
        end

    always @(posedge i_sda)
        if (!i_spi && i_scl)
            ph = 0;
        else if (i_spi)
            mq = !mq;

    // Driven by bus edges alone, so any bus speed is served.
    always @(posedge i_scl)
        if (!i_spi && ph != 0)
        begin
            if (bn == 8)
            begin
                // The read address byte is acknowledged by the model itself; only a
                // master acknowledge after a data byte moves on to the next register.
                if (ph == 4 && !ack && i_sda)
                    ph = 0;
                else if (ph == 4 && !ack)
                    ptr = ptr + 7'h01;
                bn = 0;
            end
            else
            begin
                sh = {sh[6:0], i_sda};
                bn = bn + 1;
                if (bn == 8)
                begin
                    ack = 1'h1;
                    case (ph)
                        1:
                        begin
                            if (sh[7:1] != (regs[2][2] ? 7'h4c : {5'h13, i_strap}))
                            begin
                                ack = 1'h0;
                                ph = 0;
                            end
                            else
                                ph = sh[0] ? 4 : 2;
                        end
                        2:
                        begin
                            ptr = sh[6:0];
                            ph = 3;
                        end
                        3:
                        begin
                            regs[ptr] = sh;
                            ptr = ptr + 7'h01;
                        end
                        default: ack = 1'h0;
                    endcase
                end
            end
        end

    always @(negedge i_scl)
        if (!i_spi)
            o_sda_low = (bn == 8) ? ack : (ph == 4 && !regs[ptr][7 - bn]);

    always @(posedge i_sclk)
        if (i_spi && !i_sda)
            mq = (n >= 8 && rd) ? regs[ptr][7 - n % 8] : !mq;

    always @(negedge i_sclk)
        if (i_spi && !i_sda)
        begin
            sh = {sh[6:0], i_scl};
            n = n + 1;
            if (n == 8)
                {ptr, rd} = sh;
            else if (n % 8 == 0)
            begin
                if (!rd)
                    regs[ptr] = sh;
                ptr = ptr + 7'h01;
            end
        end

    assign o_miso = i_spi ? mq : i_strap[1];
endmodule : dmcp_dev_model
`default_nettype wire

/* tb.sv */
// Self-checking bench for the host controller against the device model.
// Assumes pull-ups on the shared lines; the model's protocol is set per phase.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dmcp_pkg::*;
    logic i_clk = 1'h0;
    logic i_reset_n = 1'h0;
    logic req_valid = 1'h0;
    logic spi_mode = 1'h1;
    dmcp_req_s req = '0;
    dmcp_rsp_s rsp;
    dmcp_rsp_s got;
    logic busy, rsp_valid, sda_o, sda_oe_n, scl_o, scl_oe_n, sclk, miso, dev_low;
    wire sda;
    wire scl;
    int mismatches = 0;
    int n_checks = 0;
    int edges = 0;

    assign sda = (sda_oe_n | sda_o) & !dev_low;
    assign scl = scl_oe_n | scl_o;

    always #2.5 i_clk = !i_clk;

    dmcp_host i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req_valid(req_valid),
        .i_req(req), .o_busy(busy), .o_rsp_valid(rsp_valid), .o_rsp(rsp),
        .o_data_or_select_pin_o(sda_o), .o_data_or_select_pin_oe_n(sda_oe_n),
        .i_data_or_select_pin(sda), .o_scl_mosi_o(scl_o), .o_scl_mosi_oe_n(scl_oe_n),
        .o_addr_strap0_or_serial_clock_pin(sclk), .i_addr_strap1_or_serial_out_pin(miso));

    dmcp_dev_model i_dev (.i_spi(spi_mode), .i_strap(2'h2), .i_sda(sda), .i_scl(scl),
        .i_sclk(sclk), .o_sda_low(dev_low), .o_miso(miso));

    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'h1)
        begin
            mismatches++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // One single-byte request; the answer is sampled at the falling edge it stands in.
    task automatic xfer(input logic s, input logic r, input logic b, input logic [1:0] st,
        input logic [6:0] a, input logic [7:0] d);
        int k;
        @(posedge i_clk);
        req <= {s, r, b, st, a, d};
        req_valid <= 1'h1;
        @(posedge i_clk);
        req_valid <= 1'h0;
        repeat (2) @(negedge i_clk);
        check(busy === 1'h1, "busy after take");
        for (k = 0; k < 25000 && rsp_valid !== 1'h1; k++)
            @(negedge i_clk);
        check(rsp_valid === 1'h1, "no answer");
        got = rsp;
    endtask : xfer

    // Each frame must hold exactly sixteen clocks and leave the clock low.
    always @(posedge sclk)
        if (!sda)
            edges++;
    always @(posedge sda)
        if (spi_mode && i_reset_n)
        begin
            check(edges == 16 && sclk === 1'h0, "frame clocks");
            edges = 0;
        end

    task automatic spi_test;
        xfer(1'h1, 1'h0, 1'h0, 2'h0, 7'h21, 8'ha5);
        xfer(1'h1, 1'h0, 1'h0, 2'h0, 7'h7f, 8'h3c);
        xfer(1'h1, 1'h1, 1'h0, 2'h0, 7'h21, 8'h00);
        check(got.rdata === 8'ha5, "spi read 0x21");
        xfer(1'h1, 1'h1, 1'h0, 2'h0, 7'h7f, 8'h00);
        check(got.rdata === 8'h3c, "spi read 0x7f");
        $display("spi test done");
    endtask : spi_test

    task automatic i2c_test;
        spi_mode = 1'h0;
        xfer(1'h0, 1'h0, 1'h0, 2'h2, 7'h09, 8'h5a);
        check(got.ack_err === 1'h0, "write refused");
        xfer(1'h0, 1'h0, 1'h0, 2'h1, 7'h09, 8'h00);
        check(got.ack_err === 1'h1, "wrong strap acknowledged");
        xfer(1'h0, 1'h0, 1'h1, 2'h2, 7'h09, 8'h00);
        check(got.ack_err === 1'h1, "broadcast acknowledged while off");
        xfer(1'h0, 1'h0, 1'h0, 2'h2, 7'h02, 8'h04);
        xfer(1'h0, 1'h1, 1'h1, 2'h2, 7'h09, 8'h00);
        check(got === {1'h0, 8'h5a}, "broadcast read");
        $display("i2c test done");
    endtask : i2c_test

    initial
    begin
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'h1;
        spi_test();
        i2c_test();
        tally_and_finish();
    end

    initial
    begin
        #450000;
        mismatches++;
        $display("MISMATCH %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
